// *** design/a6s_edge_retime.sv ***
// module: falling-edge retiming of the memory strobes
`timescale 1ns/100ps
module a6s_edge_retime
	import a6s_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ce,
	input  wire logic       lsm,
	input  wire logic       cs,
	input  wire logic       strb,
	input  wire logic       wr,
	input  wire logic [3:0] lanes,
	output logic            read_strobe_n,
	output logic [3:0]      lane_select_n,
	output logic            direction_wr_n
);

	typedef struct packed {
		logic       rd_n;
		logic [3:0] ln_n;
		logic       dir_n;
	} a6s_edge_s;

	a6s_edge_s e_r;
	a6s_edge_s e_nxt;

	// ==================================================================
	// strobe shaping
	always_comb begin
		e_nxt      = e_r;
		e_nxt.rd_n = !(strb && !wr);
		if (!lsm) begin
			e_nxt.ln_n  = strb ? ~lanes : 4'hf;
			e_nxt.dir_n = !(cs && wr);
		end else begin
			e_nxt.ln_n  = cs ? ~lanes : 4'hf;
			e_nxt.dir_n = !(strb && wr);
		end
		if (!aresetn) begin
			e_nxt = '1;
		end
	end

	always_ff @(negedge aclk) begin
		if (!aresetn || ce) begin
			e_r <= e_nxt;
		end
	end

	assign read_strobe_n  = e_r.rd_n;
	assign lane_select_n  = e_r.ln_n;
	assign direction_wr_n = e_r.dir_n;

	// ==================================================================
	// checks
	a_mode0_dir_status: assert property (@(negedge aclk) disable iff (!aresetn)
		(ce && !lsm && cs && wr) |=> !direction_wr_n)
		else $error("direction not held during write with strobe mode clear");
	a_mode1_lane_status: assert property (@(negedge aclk) disable iff (!aresetn)
		(ce && lsm && cs) |=> (lane_select_n == ~$past(lanes)))
		else $error("lane selects not held during cycle with strobe mode set");
	a_strobe_quiet: assert property (@(negedge aclk) disable iff (!aresetn)
		(ce && !strb) |=> (read_strobe_n && (lsm || lane_select_n == 4'hf)))
		else $error("strobe active outside strobe window");

endmodule : a6s_edge_retime

// *** design/a6s_pkg.sv ***
// package: register map, field layout, reset values and types for the area timing block
package a6s_pkg;

	// ==================================================================
	// register map
	localparam logic [7:0]  OFF_CFG    = 8'h00;
	localparam logic [7:0]  OFF_STAT   = 8'h04;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_DEC   = 2'h3;

	// ==================================================================
	// configuration fields
	localparam int          LSM_BIT    = 20;
	localparam int          SETUP_LO   = 11;
	localparam int          WR_LO      = 7;
	localparam int          MASK_BIT   = 6;
	localparam int          HOLD_LO    = 0;
	localparam logic [31:0] CFG_MASK   = 32'h0010_1fc3;
	localparam logic [31:0] CFG_RST    = 32'h0000_0500;
	localparam logic [3:0]  WR_RST     = 4'ha;

	// ==================================================================
	// status fields
	localparam int          STAT_BUSY  = 0;
	localparam int          STAT_WAIT  = 1;

	typedef enum logic [1:0] {
		S_IDLE,
		S_SETUP,
		S_STRB,
		S_HOLD
	} a6s_fsm_e;

	// ==================================================================
	// wait code to cycle count
	function automatic logic [4:0] wait_cycles(input logic [3:0] code);
		case (code)
			4'h7:    wait_cycles = 5'h08;
			4'h8:    wait_cycles = 5'h0a;
			4'h9:    wait_cycles = 5'h0c;
			4'ha:    wait_cycles = 5'h0e;
			4'hb:    wait_cycles = 5'h12;
			4'hc:    wait_cycles = 5'h18;
			4'hd,
			4'he,
			4'hf:    wait_cycles = 5'h18;
			default: wait_cycles = {1'b0, code};
		endcase
	endfunction : wait_cycles

endpackage : a6s_pkg

// *** design/a6s_sram_timing.sv ***
// module: area timing controller with register slave and memory pins
`timescale 1ns/100ps
// Function
// - reserved configuration bits read zero
// - mode clear: lane strobe pulses, direction level
// - mode set: lane level, direction pulses
// - strobe follows select by setup code
// - access wait count from four-bit code
// - wait code resets to 1010, others zero
// - wait mask gates external wait input
// - mask works with zero wait cycles
// - select negates after strobe by hold
module a6s_sram_timing
	import a6s_pkg::*;
#(
	parameter int SA_W = 24
) (
	input  wire logic            aclk,
	input  wire logic            aresetn,
	input  wire logic            ce,
	input  wire logic [7:0]      awaddr,
	input  wire logic            awvalid,
	output logic                 awready,
	input  wire logic [31:0]     wdata,
	input  wire logic [3:0]      wstrb,
	input  wire logic            wvalid,
	output logic                 wready,
	output logic [1:0]           bresp,
	output logic                 bvalid,
	input  wire logic            bready,
	input  wire logic [7:0]      araddr,
	input  wire logic            arvalid,
	output logic                 arready,
	output logic [31:0]          rdata,
	output logic [1:0]           rresp,
	output logic                 rvalid,
	input  wire logic            rready,
	input  wire logic            acc_req,
	input  wire logic            acc_write,
	input  wire logic [SA_W-1:0] acc_addr,
	input  wire logic [31:0]     acc_wdata,
	input  wire logic [3:0]      acc_lanes,
	output logic                 acc_busy,
	output logic                 acc_done,
	output logic [31:0]          acc_rdata,
	output logic [SA_W-1:0]      sram_addr,
	output logic                 chip_select_n,
	output logic                 read_strobe_n,
	output logic [3:0]           lane_select_n,
	output logic                 direction_wr_n,
	output logic [31:0]          dq_o,
	output logic                 dq_oe,
	input  wire logic [31:0]     dq_i,
	input  wire logic            ext_wait
);

	if (SA_W < 1 || SA_W > 32) begin : g_bad_width
		$error("SA_W out of range");
	end

	typedef struct packed {
		a6s_fsm_e        st;
		logic [4:0]      cnt;
		logic [31:0]     cfg;
		logic            lsm_l;
		logic [1:0]      setup_l;
		logic [3:0]      wr_l;
		logic            mask_l;
		logic [1:0]      hold_l;
		logic            cs_n;
		logic            strb;
		logic            wr;
		logic            oe;
		logic            busy;
		logic            done;
		logic            waited;
		logic [SA_W-1:0] addr;
		logic [31:0]     wdat;
		logic [3:0]      lanes;
		logic [31:0]     rdat;
		logic            wt1;
		logic            wt2;
		logic [31:0]     dq1;
		logic [31:0]     dq2;
		logic            aw_got;
		logic            w_got;
		logic [7:0]      awa;
		logic [31:0]     wd;
		logic [3:0]      ws;
		logic            awready;
		logic            wready;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            arready;
		logic            rvalid;
		logic [1:0]      rresp;
		logic [31:0]     rdata;
	} a6s_state_s;

	a6s_state_s st_r;
	a6s_state_s st_nxt;

	// ==================================================================
	// next state
	always_comb begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		st_nxt.wt1  = ext_wait;
		st_nxt.wt2  = st_r.wt1;
		st_nxt.dq1  = dq_i;
		st_nxt.dq2  = st_r.dq1;

		// register write channel, address and data in either order
		if (awvalid && st_r.awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.awa    = awaddr;
		end
		if (wvalid && st_r.wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.wd    = wdata;
			st_nxt.ws    = wstrb;
		end
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_nxt.aw_got && st_nxt.w_got && !st_nxt.bvalid) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = RESP_OKAY;
			if (st_nxt.awa == OFF_CFG) begin
				for (int i = 0; i < 4; i++) begin
					if (st_nxt.ws[i]) begin
						st_nxt.cfg[8*i +: 8] = st_nxt.wd[8*i +: 8];
					end
				end
				st_nxt.cfg = st_nxt.cfg & CFG_MASK;
			end else if (st_nxt.awa != OFF_STAT) begin
				st_nxt.bresp = RESP_DEC;
			end
		end
		st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
		st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;

		// register read channel
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = RESP_OKAY;
			st_nxt.rdata  = 32'h0000_0000;
			case (araddr)
				OFF_CFG:  st_nxt.rdata = st_r.cfg & CFG_MASK;
				OFF_STAT: begin
					st_nxt.rdata[STAT_BUSY] = st_r.busy;
					st_nxt.rdata[STAT_WAIT] = st_r.waited;
				end
				default:  st_nxt.rresp = RESP_DEC;
			endcase
		end
		st_nxt.arready = !st_nxt.rvalid;

		// access sequencer
		case (st_r.st)
			S_IDLE: begin
				if (acc_req) begin
					st_nxt.lsm_l   = st_r.cfg[LSM_BIT];
					st_nxt.setup_l = st_r.cfg[SETUP_LO +: 2];
					st_nxt.wr_l    = st_r.cfg[WR_LO +: 4];
					st_nxt.mask_l  = st_r.cfg[MASK_BIT];
					st_nxt.hold_l  = st_r.cfg[HOLD_LO +: 2];
					st_nxt.addr   = acc_addr;
					st_nxt.wdat   = acc_wdata;
					st_nxt.lanes  = acc_lanes;
					st_nxt.wr     = acc_write;
					st_nxt.oe     = acc_write;
					st_nxt.cs_n   = 1'b0;
					st_nxt.busy   = 1'b1;
					st_nxt.waited = 1'b0;
					if (st_r.cfg[SETUP_LO +: 2] == 2'h0) begin
						st_nxt.strb = 1'b1;
						st_nxt.st   = S_STRB;
						st_nxt.cnt  = wait_cycles(st_r.cfg[WR_LO +: 4]);
					end else begin
						st_nxt.st  = S_SETUP;
						st_nxt.cnt = {3'h0, st_r.cfg[SETUP_LO +: 2]};
					end
				end
			end
			S_SETUP: begin
				if (st_r.cnt == 5'h01) begin
					st_nxt.strb = 1'b1;
					st_nxt.st   = S_STRB;
					st_nxt.cnt  = wait_cycles(st_r.wr_l);
				end else begin
					st_nxt.cnt = st_r.cnt - 5'h01;
				end
			end
			S_STRB: begin
				if (st_r.cnt != 5'h00) begin
					st_nxt.cnt = st_r.cnt - 5'h01;
				end else if (st_r.wt2 && !st_r.mask_l) begin
					st_nxt.waited = 1'b1;
				end else begin
					st_nxt.strb = 1'b0;
					st_nxt.rdat = st_r.dq2;
					st_nxt.st   = S_HOLD;
					st_nxt.cnt  = {3'h0, st_r.hold_l};
				end
			end
			S_HOLD: begin
				if (st_r.cnt == 5'h00) begin
					st_nxt.cs_n = 1'b1;
					st_nxt.oe   = 1'b0;
					st_nxt.busy = 1'b0;
					st_nxt.done = 1'b1;
					st_nxt.st   = S_IDLE;
				end else begin
					st_nxt.cnt = st_r.cnt - 5'h01;
				end
			end
			default: st_nxt.st = S_IDLE;
		endcase

		if (!aresetn) begin
			st_nxt         = '0;
			st_nxt.st      = S_IDLE;
			st_nxt.cfg     = CFG_RST;
			st_nxt.cs_n    = 1'b1;
			st_nxt.awready = 1'b1;
			st_nxt.wready  = 1'b1;
			st_nxt.arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || ce) begin
			st_r <= st_nxt;
		end
	end

	// ==================================================================
	// outputs
	assign awready       = st_r.awready;
	assign wready        = st_r.wready;
	assign bvalid        = st_r.bvalid;
	assign bresp         = st_r.bresp;
	assign arready       = st_r.arready;
	assign rvalid        = st_r.rvalid;
	assign rresp         = st_r.rresp;
	assign rdata         = st_r.rdata;
	assign acc_busy      = st_r.busy;
	assign acc_done      = st_r.done;
	assign acc_rdata     = st_r.rdat;
	assign sram_addr     = st_r.addr;
	assign chip_select_n = st_r.cs_n;
	assign dq_o          = st_r.wdat;
	assign dq_oe         = st_r.oe;

	a6s_edge_retime u_edge (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.ce             (ce),
		.lsm            (st_r.lsm_l),
		.cs             (!st_r.cs_n),
		.strb           (st_r.strb),
		.wr             (st_r.wr),
		.lanes          (st_r.lanes),
		.read_strobe_n  (read_strobe_n),
		.lane_select_n  (lane_select_n),
		.direction_wr_n (direction_wr_n)
	);

	// ==================================================================
	// checks
	logic [7:0] gap_c;
	logic [7:0] len_c;
	logic [7:0] hold_c;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_c  <= 8'h00;
			len_c  <= 8'h00;
			hold_c <= 8'h00;
		end else if (ce) begin
			gap_c  <= (st_r.cs_n && !st_nxt.cs_n) ? 8'h00 : gap_c + 8'h01;
			len_c  <= (!st_r.strb && st_nxt.strb) ? 8'h00 : len_c + 8'h01;
			hold_c <= (st_r.strb && !st_nxt.strb) ? 8'h00 : hold_c + 8'h01;
		end
	end

	sequence strb_last;
		st_r.st == S_STRB && st_r.cnt == 5'h00 && ce;
	endsequence

	a_cfg_reset_val: assert property (@(posedge aclk)
		!aresetn |=> (st_r.cfg == CFG_RST && st_r.cfg[WR_LO +: 4] == WR_RST))
		else $error("configuration reset value wrong");
	a_rsvd_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(arvalid && arready && araddr == OFF_CFG) |=> ((rdata & ~CFG_MASK) == 32'h0))
		else $error("reserved bits read nonzero");
	a_setup_gap: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(st_r.strb) |-> (gap_c == {6'h00, st_r.setup_l}))
		else $error("setup delay mismatch");
	a_wait_length: assert property (@(posedge aclk) disable iff (!aresetn)
		($fell(st_r.strb) && st_r.mask_l) |-> (len_c == {3'h0, wait_cycles(st_r.wr_l)} + 8'h01))
		else $error("access wait length mismatch");
	a_ext_stretch: assert property (@(posedge aclk) disable iff (!aresetn)
		(strb_last and (st_r.wt2 && !st_r.mask_l)) |=> st_r.strb)
		else $error("external wait did not stretch access");
	a_wait_masked: assert property (@(posedge aclk) disable iff (!aresetn)
		(strb_last and st_r.mask_l) |=> (!st_r.strb ##1 1'b1))
		else $error("masked wait stretched access");
	a_hold_gap: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(st_r.cs_n) |-> (hold_c == {6'h00, st_r.hold_l} + 8'h01))
		else $error("hold delay mismatch");
	a_cfg_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r.st != S_IDLE && $past(st_r.st) != S_IDLE) |->
			$stable({st_r.lsm_l, st_r.setup_l, st_r.wr_l, st_r.mask_l, st_r.hold_l}))
		else $error("timing changed during access");

endmodule : a6s_sram_timing

// *** sim/a6s_sram_model.sv ***
// file: behavioural external memory with an external wait generator
`timescale 1ns/100ps
module a6s_sram_model #(
	parameter int SA_W = 24
) (
	input  wire logic            aclk,
	input  wire logic [SA_W-1:0] sram_addr,
	input  wire logic            chip_select_n,
	input  wire logic            read_strobe_n,
	input  wire logic [3:0]      lane_select_n,
	input  wire logic            direction_wr_n,
	input  wire logic [31:0]     dq_o,
	input  wire logic            dq_oe,
	input  wire logic [3:0]      stall,
	output logic [31:0]          dq_i,
	output logic                 ext_wait
);
	logic [31:0] mem [16];
	logic [3:0]  cnt;

	initial begin
		dq_i = 32'h0;
		cnt = 4'h0;
	end

	// ==========
	// data array, byte lanes written while selected and driven
	always @(aclk) begin
		if (!chip_select_n && dq_oe && !direction_wr_n) begin
			for (int k = 0; k < 4; k++) begin
				if (!lane_select_n[k]) mem[sram_addr[3:0]][8*k +: 8] <= dq_o[8*k +: 8];
			end
		end
		dq_i <= (!chip_select_n && !read_strobe_n) ? mem[sram_addr[3:0]] : ~dq_i;
	end

	// ==========
	// wait request held for stall cycles from select
	always @(posedge aclk) begin
		if (chip_select_n) cnt <= stall;
		else if (cnt != 4'h0) cnt <= cnt - 4'h1;
	end
	assign ext_wait = !chip_select_n && (cnt != 4'h0);
endmodule : a6s_sram_model

// *** sim/a6s_sram_timing_tb_top.sv ***
// file: self-checking bench for the area timing controller
`timescale 1ns/100ps
module a6s_sram_timing_tb_top
	import a6s_pkg::*;
;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, acc_req, acc_write, acc_busy, acc_done;
	logic        chip_select_n, read_strobe_n, direction_wr_n, dq_oe, ext_wait;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, acc_wdata, acc_rdata, dq_o, dq_i;
	logic [1:0]  bresp, rresp;
	logic [3:0]  wstrb, acc_lanes, lane_select_n, stall;
	logic [23:0] acc_addr, sram_addr;
	logic        tb_wr, tb_lsm, stat_ok, strb_n;
	int          fail_count, total_checks;
	realtime     t0, t1, t2, t3;
	localparam int WT [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};

	a6s_sram_timing u_a6s_sram_timing (
		.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .acc_req, .acc_write, .acc_addr, .acc_wdata, .acc_lanes, .acc_busy,
		.acc_done, .acc_rdata, .sram_addr, .chip_select_n, .read_strobe_n, .lane_select_n,
		.direction_wr_n, .dq_o, .dq_oe, .dq_i, .ext_wait
	);
	a6s_sram_model u_a6s_sram_model (
		.aclk, .sram_addr, .chip_select_n, .read_strobe_n, .lane_select_n,
		.direction_wr_n, .dq_o, .dq_oe, .stall, .dq_i, .ext_wait
	);

	// ==========
	// clock and pin edge timing
	always #2 aclk = ~aclk;
	assign strb_n = tb_wr ? (tb_lsm ? direction_wr_n : &lane_select_n) : read_strobe_n;
	always @(negedge chip_select_n) t0 = $realtime;
	always @(negedge strb_n) t1 = $realtime;
	always @(posedge chip_select_n) t3 = $realtime;
	always @(posedge strb_n) begin
		t2 = $realtime;
		stat_ok = tb_lsm ? (lane_select_n === ~acc_lanes) : (!tb_wr || direction_wr_n === 1'b0);
	end

	// ==========
	// compare and report
	function automatic logic [31:0] hc(input realtime t);
		return 32'(int'(t / 2.0));
	endfunction : hc

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	task automatic tmo(input logic ok);
		if (!ok) begin
			fail_count++;
			end_of_test();
		end
	endtask : tmo

	// ==========
	// register bus
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int   n;
		logic ok;
		n = 0;
		ok = 1'b0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!ok && n < 50) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				ok = 1'b1;
				bready <= 1'b0;
				chk("bresp", 32'(bresp), 32'(r));
			end
		end
		tmo(ok);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int   n;
		logic ok;
		n = 0;
		ok = 1'b0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (!ok && n < 50) begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				ok = 1'b1;
				rready <= 1'b0;
				chk("rdata", rdata, d);
				chk("rresp", 32'(rresp), 32'(r));
			end
		end
		tmo(ok);
	endtask : axi_rd

	task automatic cfg(input logic b, input logic [1:0] su, input logic [3:0] wc,
			input logic mk, input logic [1:0] ho);
		tb_lsm = b;
		axi_wr(OFF_CFG, {11'h0, b, 7'h0, su, wc, mk, 4'h0, ho}, RESP_OKAY);
	endtask : cfg

	// ==========
	// memory access with setup, width and hold given in cycles, checked in half cycles
	task automatic acc(input logic w, input logic [3:0] ln, input logic [31:0] d,
			input int su, input int ho, input int wc);
		int   n;
		logic ok;
		n = 0;
		ok = 1'b0;
		tb_wr = w;
		@(posedge aclk);
		acc_req   <= 1'b1;
		acc_write <= w;
		acc_lanes <= ln;
		acc_wdata <= d;
		while (!ok && n < 200) begin
			@(posedge aclk);
			n++;
			if (acc_busy === 1'b1) acc_req <= 1'b0;
			ok = (acc_done === 1'b1);
		end
		tmo(ok);
		chk("setup", hc(t1 - t0), 32'(2 * su + 1));
		if (wc >= 0) chk("width", hc(t2 - t1), 32'(2 * wc + 2));
		chk("hold", hc(t3 - t2), 32'(2 * ho + 1));
		chk("status", 32'(stat_ok), 32'h1);
	endtask : acc

	// ==========
	// main sequence
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, acc_req, acc_write} = '0;
		{awaddr, araddr, wdata, acc_wdata, acc_lanes} = '0;
		{stall, tb_wr, tb_lsm, stat_ok, fail_count, total_checks} = '0;
		acc_addr = 24'h5;
		wstrb = 4'hf;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(OFF_CFG, CFG_RST, RESP_OKAY);
		acc(1'b1, 4'hf, 32'h1122_3344, 0, 0, 14);
		acc(1'b1, 4'h5, 32'haabb_ccdd, 0, 0, 14);
		acc(1'b0, 4'hf, 32'h0, 0, 0, 14);
		chk("acc_rdata", acc_rdata, 32'h11bb_33dd);
		axi_wr(OFF_CFG, 32'hffff_fe7f, RESP_OKAY);
		axi_rd(OFF_CFG, 32'h0010_1e43, RESP_OKAY);
		axi_wr(8'h08, 32'h0, RESP_DEC);
		axi_rd(8'h08, 32'h0, RESP_DEC);
		for (int c = 0; c < 13; c++) begin
			cfg(c[0], 2'(c), 4'(c), 1'b1, 2'(c + 1));
			acc(1'b1, 4'h6, 32'h0, c % 4, (c + 1) % 4, WT[c]);
			acc(1'b0, 4'h9, 32'h0, c % 4, (c + 1) % 4, WT[c]);
		end
		stall <= 4'h6;
		cfg(1'b0, 2'h2, 4'h0, 1'b0, 2'h0);
		acc(1'b0, 4'hf, 32'h0, 2, 0, -1);
		chk("stretch", 32'(hc(t2 - t1) > 32'h2), 32'h1);
		axi_rd(OFF_STAT, 32'h2, RESP_OKAY);
		cfg(1'b0, 2'h2, 4'h0, 1'b1, 2'h0);
		acc(1'b0, 4'hf, 32'h0, 2, 0, 0);
		axi_rd(OFF_STAT, 32'h0, RESP_OKAY);
		stall <= 4'h0;
		cfg(1'b0, 2'h0, 4'h2, 1'b1, 2'h0);
		fork
			acc(1'b0, 4'hf, 32'h0, 0, 0, 2);
			axi_wr(OFF_CFG, 32'h0000_0340, RESP_OKAY);
		join
		acc(1'b0, 4'hf, 32'h0, 0, 0, 6);
		end_of_test();
	end
endmodule : a6s_sram_timing_tb_top
